/* File: rtl/overcurrent_pkg.sv */
`default_nettype none
package overcurrent_pkg;
    // Command codes of the register map.
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_FAULT_ACTION = 8'h41;
    localparam logic [7:0] CMD_FAULT_THRESHOLD = 8'h46;
    localparam logic [7:0] CMD_STATUS_CURRENT = 8'h7b;
    localparam logic [7:0] CMD_DELAY_UNIT = 8'hd2;
    // Field positions of the fault action byte.
    localparam int ACT_RESP_HI = 7;
    localparam int ACT_RESP_LO = 6;
    localparam int ACT_RETRY_HI = 5;
    localparam int ACT_RETRY_LO = 3;
    localparam int ACT_DELAY_HI = 2;
    localparam int ACT_DELAY_LO = 0;
    // Status byte bits.
    localparam int STAT_OC_FAULT = 7;
    localparam int STAT_OC_OFF = 6;
    // Response codes and special retry codes.
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_RIDE = 2'h1;
    localparam logic [1:0] RESP_DISABLE = 2'h2;
    localparam logic [1:0] RESP_HOLD = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // Values after reset.
    localparam logic [7:0] ACTION_RESET = 8'h80;
    localparam logic [15:0] THRESHOLD_RESET = 16'hf8c8;
    localparam logic [15:0] DELAY_UNIT_RESET = 16'h0001;
    // Time base: the delay unit register counts microseconds.
    localparam int CLK_MHZ = 100;
    localparam int US_TIME = 1;
    localparam int US_CYCLES = US_TIME * CLK_MHZ;
    localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_RUN = 7'h02,
        ST_RIDE = 7'h04,
        ST_HOLD = 7'h08,
        ST_WAIT = 7'h10,
        ST_RESTART = 7'h20,
        ST_LATCH = 7'h40
    } oc_state_t;
endpackage : overcurrent_pkg
`default_nettype wire

/* File: rtl/overcurrent_fault_response.sv */
`default_nettype none
// Notes on behaviour
// - Fault threshold is a 16-bit linear-format current value.
// - Response action comes from bits 7:6 of the action register.
// - Action 00 keeps the output running through the fault.
// - Action 01 rides through the delay, then follows the retry setting if fault remains.
// - Action 10 disables output at once, then follows the retry setting.
// - Action 11 holds output off only while the fault persists.
// - Retry code 000 never restarts; output stays off until cleared.
// - Retry codes 001..011 give one to three attempts, then latch off.
// - Attempt starts are spaced by two to the power of the delay count, times the unit.
// - Retry code 111 restarts without limit.
// - Status clear, clear-faults command or reset clear the latched fault.
// - Commanding output off then on clears the latched fault.
// - Delay count 0..7 means 1 to 128 delay units.
// - Delay unit length comes from register 0xd2.
// - Retry codes 100..110 give four to six attempts, then latch off.
// - Endless retry stops on off command or another shutdown fault.
module overcurrent_fault_response
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic srst,
    // Command port.
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic rsp_valid_reg,
    output logic rsp_error_reg,
    output logic [15:0] rsp_rdata_reg,
    // Power stage.
    input wire logic [15:0] iout_meas,
    input wire logic output_on_cmd,
    input wire logic other_fault,
    output logic output_enable_reg,
    output logic oc_fault_flag_reg
);
    import overcurrent_pkg::*;

    logic [7:0] action_reg;
    logic [15:0] threshold_reg;
    logic [15:0] delay_unit_reg;
    logic [6:0] us_count_reg;
    logic [15:0] unit_count_reg;
    logic [7:0] timer_reg;
    logic [7:0] timer_next;
    logic [2:0] retries_reg;
    logic [2:0] retries_next;
    logic on_prev_reg;
    oc_state_t state_reg;
    oc_state_t state_next;

    function automatic logic [41:0] lin_to_fixed(input logic [15:0] v);
        logic [41:0] m;
        logic [4:0] sh;
        m = {32'h0, v[9:0]};
        sh = {~v[15], v[14:11]};
        if (v[10]) begin
            lin_to_fixed = 42'h0;
        end else begin
            lin_to_fixed = m << sh;
        end
    endfunction : lin_to_fixed

    // Command decode.
    wire wr = cmd_valid && cmd_write;
    wire rd = cmd_valid && !cmd_write;
    wire wr_action = wr && (cmd_code == CMD_FAULT_ACTION);
    wire wr_thresh = wr && (cmd_code == CMD_FAULT_THRESHOLD);
    wire wr_unit = wr && (cmd_code == CMD_DELAY_UNIT);
    wire clear_cmd = wr && (cmd_code == CMD_CLEAR_FAULTS);
    wire clear_bit = wr && (cmd_code == CMD_STATUS_CURRENT) && cmd_wdata[STAT_OC_FAULT];
    wire clear_any = clear_cmd || clear_bit;
    wire on_rise = output_on_cmd && !on_prev_reg;
    wire code_known = (cmd_code == CMD_FAULT_ACTION) || (cmd_code == CMD_FAULT_THRESHOLD) ||
                      (cmd_code == CMD_DELAY_UNIT) || (cmd_code == CMD_STATUS_CURRENT) ||
                      (cmd_code == CMD_CLEAR_FAULTS && cmd_write);

    // Action fields.
    // response field
    wire [1:0] resp = action_reg[ACT_RESP_HI:ACT_RESP_LO];
    wire [2:0] retry_set = action_reg[ACT_RETRY_HI:ACT_RETRY_LO];
    wire [2:0] delay_cnt = action_reg[ACT_DELAY_HI:ACT_DELAY_LO];
    wire [7:0] delay_units = 8'h01 << delay_cnt;
    wire retry_forever = (retry_set == RETRY_FOREVER);

    wire oc_detect = lin_to_fixed(iout_meas) > lin_to_fixed(threshold_reg);

    wire [15:0] unit_len = (delay_unit_reg == 16'h0) ? 16'h0001 : delay_unit_reg;
    wire us_tick = (us_count_reg == US_LAST);
    wire unit_tick = us_tick && (unit_count_reg >= unit_len - 16'h0001);
    wire timer_done = (timer_reg == 8'h0);

    wire [7:0] status_byte = {oc_fault_flag_reg, ~output_enable_reg & ~state_reg[0], 6'h0};
    wire [15:0] rd_mux = (cmd_code == CMD_FAULT_ACTION) ? {8'h0, action_reg} :
                         (cmd_code == CMD_FAULT_THRESHOLD) ? threshold_reg :
                         (cmd_code == CMD_DELAY_UNIT) ? delay_unit_reg :
                         (cmd_code == CMD_STATUS_CURRENT) ? {8'h0, status_byte} : 16'h0;

    wire out_en_next = (state_next == ST_RUN) || (state_next == ST_RIDE) ||
                       (state_next == ST_RESTART);

    always_comb begin
        state_next = state_reg;
        timer_next = (unit_tick && !timer_done) ? timer_reg - 8'h01 : timer_reg;
        retries_next = retries_reg;
        if (!output_on_cmd) begin
            state_next = ST_OFF;
        end else if (on_rise || state_reg == ST_OFF) begin
            state_next = ST_RUN;
        end else if (other_fault) begin
            state_next = ST_LATCH;
        end else if (clear_any && state_reg != ST_RUN && state_reg != ST_RIDE) begin
            state_next = ST_RUN;
        end else begin
            unique case (state_reg)
                ST_RUN: begin
                    if (oc_detect) begin
                        unique case (resp)
                            RESP_IGNORE: state_next = ST_RUN;
                            RESP_RIDE: begin
                                state_next = ST_RIDE;
                                timer_next = delay_units;
                            end
                            RESP_DISABLE: begin
                                state_next = (retry_set == RETRY_NONE) ? ST_LATCH : ST_WAIT;
                                timer_next = delay_units;
                                retries_next = retry_set;
                            end
                            RESP_HOLD: state_next = ST_HOLD;
                        endcase
                    end
                end
                ST_RIDE: begin
                    if (timer_done) begin
                        state_next = !oc_detect ? ST_RUN :
                                     (retry_set == RETRY_NONE) ? ST_LATCH : ST_WAIT;
                        timer_next = delay_units;
                        retries_next = retry_set;
                    end
                end
                ST_HOLD: begin
                    if (!oc_detect) begin
                        state_next = ST_RUN;
                    end
                end
                ST_WAIT: begin
                    if (timer_done) begin
                        state_next = ST_RESTART;
                        timer_next = delay_units;
                    end
                end
                ST_RESTART: begin
                    if (oc_detect) begin
                        if (!retry_forever && retries_reg == 3'h1) begin
                            state_next = ST_LATCH;
                        end else begin
                            state_next = ST_WAIT;
                            retries_next = retry_forever ? retries_reg : retries_reg - 3'h1;
                        end
                    end else if (timer_done) begin
                        state_next = ST_RUN;
                    end
                end
                ST_LATCH: state_next = ST_LATCH;
                default: state_next = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            action_reg <= ACTION_RESET;
            threshold_reg <= THRESHOLD_RESET;
            delay_unit_reg <= DELAY_UNIT_RESET;
        end else begin
            if (wr_action) begin
                action_reg <= cmd_wdata[7:0];
            end
            if (wr_thresh) begin
                threshold_reg <= cmd_wdata;
            end
            if (wr_unit) begin
                delay_unit_reg <= cmd_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            us_count_reg <= 7'h0;
            unit_count_reg <= 16'h0;
        end else begin
            us_count_reg <= us_tick ? 7'h0 : us_count_reg + 7'h01;
            if (us_tick) begin
                unit_count_reg <= unit_tick ? 16'h0 : unit_count_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_OFF;
            timer_reg <= 8'h0;
            retries_reg <= 3'h0;
            on_prev_reg <= 1'b0;
            output_enable_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            retries_reg <= retries_next;
            on_prev_reg <= output_on_cmd;
            output_enable_reg <= out_en_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            oc_fault_flag_reg <= 1'b0;
        end else if (oc_detect) begin
            oc_fault_flag_reg <= 1'b1;
        end else if (clear_any || on_rise) begin
            oc_fault_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rsp_valid_reg <= 1'b0;
            rsp_error_reg <= 1'b0;
            rsp_rdata_reg <= 16'h0;
        end else begin
            rsp_valid_reg <= cmd_valid;
            rsp_error_reg <= cmd_valid && !code_known;
            rsp_rdata_reg <= rd ? rd_mux : 16'h0;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    wire quiet = output_on_cmd && !on_rise && !other_fault && !clear_any;

    AST_IGNORE_RUNS: assert property (
        state_reg == ST_RUN && oc_detect && resp == RESP_IGNORE && quiet
        |=> state_reg == ST_RUN && output_enable_reg)
        else $error("ignore response left the run state");

    AST_RIDE_KEEPS_OUTPUT: assert property (
        state_reg == ST_RUN && oc_detect && resp == RESP_RIDE && quiet
        |=> state_reg == ST_RIDE && timer_reg == $past(delay_units) && output_enable_reg)
        else $error("ride-through did not keep output on");

    AST_DISABLE_AT_ONCE: assert property (
        state_reg == ST_RUN && oc_detect && resp == RESP_DISABLE && quiet
        |=> !output_enable_reg)
        else $error("disable response kept output on");

    AST_HOLD_RESUMES: assert property (
        state_reg == ST_HOLD && !oc_detect && quiet |=> output_enable_reg)
        else $error("hold did not resume after fault cleared");

    AST_LATCH_STAYS: assert property (
        state_reg == ST_LATCH && quiet |=> state_reg == ST_LATCH && !output_enable_reg)
        else $error("latched disable released without clear");

    AST_LAST_ATTEMPT_LATCHES: assert property (
        state_reg == ST_RESTART && oc_detect && quiet && !retry_forever && retries_reg == 3'h1
        |=> state_reg == ST_LATCH)
        else $error("last failed attempt did not latch");

    AST_RETRY_SPENT: assert property (
        state_reg == ST_RESTART && oc_detect && quiet && !retry_forever && retries_reg > 3'h1
        |=> state_reg == ST_WAIT && retries_reg == $past(retries_reg) - 3'h1)
        else $error("failed attempt did not spend a retry");

    AST_FOREVER_KEEPS: assert property (
        state_reg == ST_RESTART && oc_detect && quiet && retry_forever |=> state_reg == ST_WAIT)
        else $error("endless retry stopped");

    AST_FLAG_SET: assert property (
        oc_detect |=> oc_fault_flag_reg)
        else $error("fault flag not set on over-current");

    AST_CLEAR_FAULTS: assert property (
        clear_cmd && !oc_detect |=> !oc_fault_flag_reg)
        else $error("clear-faults did not clear the flag");

    AST_OFF_STOPS: assert property (
        !output_on_cmd |=> !output_enable_reg)
        else $error("output stayed on while commanded off");

    AST_CYCLE_CLEARS: assert property (
        on_rise && !other_fault
        |=> state_reg == ST_RUN && output_enable_reg && oc_fault_flag_reg == $past(oc_detect))
        else $error("off-then-on did not clear latch");

    COV_RIDE: cover property (state_reg == ST_RIDE ##1 state_reg == ST_WAIT);
    COV_RETRY_OK: cover property (state_reg == ST_RESTART ##1 state_reg == ST_RUN);
    COV_LATCH: cover property (state_reg == ST_RESTART ##1 state_reg == ST_LATCH);
    COV_HOLD: cover property (state_reg == ST_HOLD ##1 state_reg == ST_RUN);
endmodule : overcurrent_fault_response
`default_nettype wire

/* File: verif/pmbus_host_model.sv */
`default_nettype none
module pmbus_host_model
(
    // Clock.
    input wire logic mclk,
    // Command port.
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic rsp_valid_reg,
    input wire logic rsp_error_reg,
    input wire logic [15:0] rsp_rdata_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    import overcurrent_pkg::*;
    logic [15:0] rdata;
    logic err;
    logic got;
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // One command, answer taken 1 ns after the taking edge.
    // Released code and data lines carry the inverse of the last value.
    task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] d);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code <= code;
        cmd_wdata <= d;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        cmd_wdata <= ~d;
        #1;
        got = rsp_valid_reg;
        err = rsp_error_reg;
        rdata = rsp_rdata_reg;
    endtask : xfer
    task automatic clear_faults();
        xfer(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    endtask : clear_faults
    task automatic clear_status();
        xfer(1'b1, CMD_STATUS_CURRENT, 16'h0080);
    endtask : clear_status
endmodule : pmbus_host_model
`default_nettype wire

/* File: verif/test_overcurrent_fault_response.sv */
`default_nettype none
module test_overcurrent_fault_response;
    timeunit 1ns;
    timeprecision 1ps;
    import overcurrent_pkg::*;
    localparam logic [15:0] I_OK = 16'h0032;
    localparam logic [15:0] I_LIM = 16'h0064;
    localparam logic [15:0] I_HI = 16'h00c8;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid, cmd_write, rsp_valid_reg, rsp_error_reg;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rsp_rdata_reg;
    logic [15:0] iout_meas = I_OK;
    logic output_on_cmd = 1'b0;
    logic other_fault = 1'b0;
    logic output_enable_reg, oc_fault_flag_reg;
    int err_total = 0;
    int tests_run = 0;
    int gap = 0;
    int cnt;
    always #5 mclk = ~mclk;
    overcurrent_fault_response overcurrent_fault_response_inst (
        .mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid_reg(rsp_valid_reg),
        .rsp_error_reg(rsp_error_reg), .rsp_rdata_reg(rsp_rdata_reg),
        .iout_meas(iout_meas), .output_on_cmd(output_on_cmd), .other_fault(other_fault),
        .output_enable_reg(output_enable_reg), .oc_fault_flag_reg(oc_fault_flag_reg));
    pmbus_host_model host_inst (
        .mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid_reg(rsp_valid_reg),
        .rsp_error_reg(rsp_error_reg), .rsp_rdata_reg(rsp_rdata_reg));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        $display("Counts: tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic drive(input logic [15:0] cur, input logic on, input logic oth);
        @(posedge mclk);
        iout_meas <= cur;
        output_on_cmd <= on;
        other_fault <= oth;
    endtask : drive
    // Counts rises of the output enable over n cycles; gap is the last spacing.
    task automatic rises(input int n);
        logic prev;
        int last;
        cnt = 0;
        last = 0;
        prev = output_enable_reg;
        for (int i = 0; i < n; i++) begin
            cyc(1);
            if (output_enable_reg === 1'b1 && prev === 1'b0) begin
                cnt++;
                gap = i - last;
                last = i;
            end
            prev = output_enable_reg;
        end
    endtask : rises
    // Removes the fault, clears, sets the action and waits for the output.
    task automatic restore(input logic [7:0] act);
        int k;
        drive(I_OK, 1'b1, 1'b0);
        host_inst.clear_faults();
        host_inst.xfer(1'b1, CMD_FAULT_ACTION, {8'h00, act});
        k = 0;
        while (output_enable_reg !== 1'b1 && k < 50) begin
            cyc(1);
            k++;
        end
        if (k == 50) begin
            err_total++;
            final_report();
        end
    endtask : restore
    task automatic t_regs();
        host_inst.xfer(1'b0, CMD_FAULT_ACTION, 16'h0000);
        check(host_inst.rdata, 16'h0080);
        host_inst.xfer(1'b0, CMD_FAULT_THRESHOLD, 16'h0000);
        check(host_inst.rdata, 16'hf8c8);
        host_inst.xfer(1'b1, CMD_FAULT_THRESHOLD, I_LIM);
        host_inst.xfer(1'b0, CMD_FAULT_THRESHOLD, 16'h0000);
        check(host_inst.rdata, I_LIM);
        host_inst.xfer(1'b0, CMD_DELAY_UNIT, 16'h0000);
        check(host_inst.rdata, 16'h0001);
        host_inst.xfer(1'b0, 8'h55, 16'h0000);
        check({host_inst.got, host_inst.err, host_inst.rdata[13:0]}, 16'hc000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_ignore();
        restore(8'h00);
        drive(I_LIM, 1'b1, 1'b0);
        cyc(4);
        check(oc_fault_flag_reg, 1'b0);
        drive(I_HI, 1'b1, 1'b0);
        cyc(4);
        check({oc_fault_flag_reg, output_enable_reg}, 2'h3);
        host_inst.xfer(1'b0, CMD_STATUS_CURRENT, 16'h0000);
        check(host_inst.rdata[7], 1'b1);
        drive(I_OK, 1'b1, 1'b0);
        host_inst.clear_status();
        cyc(2);
        check(oc_fault_flag_reg, 1'b0);
        $display("test ignore done");
    endtask : t_ignore
    task automatic t_latch();
        restore(8'h80);
        drive(I_HI, 1'b1, 1'b0);
        cyc(3);
        check(output_enable_reg, 1'b0);
        drive(I_OK, 1'b1, 1'b0);
        cyc(500);
        check(output_enable_reg, 1'b0);
        host_inst.xfer(1'b0, CMD_STATUS_CURRENT, 16'h0000);
        check(host_inst.rdata, 16'h00c0);
        host_inst.clear_faults();
        cyc(3);
        check({oc_fault_flag_reg, output_enable_reg}, 2'h1);
        $display("test latch done");
    endtask : t_latch
    // A reset in mid-run drops the latched fault and restores the registers.
    task automatic t_reset();
        drive(I_HI, 1'b1, 1'b0);
        cyc(3);
        check({oc_fault_flag_reg, output_enable_reg}, 2'h2);
        @(posedge mclk);
        srst <= 1'b1;
        cyc(3);
        check({oc_fault_flag_reg, output_enable_reg}, 2'h0);
        drive(I_OK, 1'b1, 1'b0);
        srst <= 1'b0;
        cyc(3);
        check({oc_fault_flag_reg, output_enable_reg}, 2'h1);
        host_inst.xfer(1'b0, CMD_FAULT_ACTION, 16'h0000);
        check(host_inst.rdata, {8'h00, ACTION_RESET});
        host_inst.xfer(1'b1, CMD_FAULT_THRESHOLD, I_LIM);
        $display("test reset done");
    endtask : t_reset
    task automatic t_retry();
        for (int n = 1; n <= 6; n++) begin
            restore({2'b10, 3'(n), 3'h0});
            drive(I_HI, 1'b1, 1'b0);
            rises(200 * (n + 2));
            check(16'(cnt), 16'(n));
            check(output_enable_reg, 1'b0);
            drive(I_OK, 1'b0, 1'b0);
            cyc(3);
            drive(I_OK, 1'b1, 1'b0);
            cyc(4);
            check(output_enable_reg, 1'b1);
        end
        $display("test retry done");
    endtask : t_retry
    task automatic t_forever();
        restore(8'hba);
        drive(I_HI, 1'b1, 1'b0);
        rises(1500);
        check(cnt >= 3, 1'b1);
        check(gap >= 300 && gap <= 401, 1'b1);
        drive(I_HI, 1'b0, 1'b0);
        rises(1000);
        check({15'(cnt), output_enable_reg}, 16'h0);
        restore(8'hb8);
        drive(I_HI, 1'b1, 1'b1);
        rises(1000);
        check({15'(cnt), output_enable_reg}, 16'h0);
        $display("test forever done");
    endtask : t_forever
    task automatic t_ride_hold();
        host_inst.xfer(1'b1, CMD_DELAY_UNIT, 16'h0002);
        restore(8'h41);
        drive(I_HI, 1'b1, 1'b0);
        cyc(150);
        check(output_enable_reg, 1'b1);
        cyc(300);
        check(output_enable_reg, 1'b0);
        restore(8'h49);
        drive(I_HI, 1'b1, 1'b0);
        rises(1100);
        check(16'(cnt), 16'h0001);
        check(output_enable_reg, 1'b0);
        host_inst.xfer(1'b1, CMD_DELAY_UNIT, 16'h0001);
        restore(8'hc0);
        drive(I_HI, 1'b1, 1'b0);
        cyc(300);
        check(output_enable_reg, 1'b0);
        drive(I_OK, 1'b1, 1'b0);
        cyc(4);
        check(output_enable_reg, 1'b1);
        $display("test ride and hold done");
    endtask : t_ride_hold
    initial begin
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        t_regs();
        t_ignore();
        t_latch();
        t_reset();
        t_retry();
        t_forever();
        t_ride_hold();
        final_report();
    end
endmodule : test_overcurrent_fault_response
`default_nettype wire
